// [design/aqh_pkg.sv]
package aqh_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL  = 8'h80;
    localparam logic [7:0] ADDR_STATUS   = 8'h84;
    localparam logic [7:0] ADDR_REQ_NEXT = 8'h88;
    localparam logic [7:0] ADDR_REQ_LAST = 8'h8c;
    localparam logic [7:0] ADDR_RSP_NEXT = 8'h90;
    localparam logic [7:0] ADDR_RSP_LAST = 8'h94;
    localparam logic [7:0] ADDR_EVENTS   = 8'ha0;

    // ------------------------------------------------------------
    // async_control fields and reset
    // ------------------------------------------------------------
    localparam logic [31:0] CONTROL_RESET  = 32'h00300320;
    localparam logic [31:0] CONTROL_MASK   = 32'h00ffffff;
    localparam int          BIT_BCAST      = 23;
    localparam int          BIT_RX_RESET   = 22;
    localparam int          BIT_TX_RESET   = 21;
    localparam int          BIT_ALL_RSP    = 20;
    localparam int          RETRY_LSB      = 16;
    localparam int          TOS_LSB        = 13;
    localparam logic [5:0]  BCAST_NODE     = 6'h3f;

    // ------------------------------------------------------------
    // event register bits, status reset
    // ------------------------------------------------------------
    localparam int          EV_REQ_WR      = 0;
    localparam int          EV_RSP_WR      = 1;
    localparam int          EV_REQ_ERR     = 2;
    localparam int          EV_RSP_ERR     = 3;
    localparam int          EV_TIMEOUT     = 7;
    localparam logic [31:0] EVENTS_MASK    = 32'h0000008f;
    localparam logic [31:0] STATUS_RESET   = 32'h00033333;

    // ------------------------------------------------------------
    // queues and timing
    // ------------------------------------------------------------
    localparam int          QUEUE_DEPTH    = 8;
    localparam int          FIVE_FREE      = 5;
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          UNITS_PER_SEC  = 8000;
    localparam int          CYC_PER_UNIT   = CLK_HZ / UNITS_PER_SEC;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } aqh_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } aqh_wb_rsp_t;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } aqh_tx_quad_t;

    typedef struct packed {
        logic        valid;
        logic [5:0]  dest_node;
        logic        is_response;
        logic        solicited;
    } aqh_rx_quad_t;

endpackage

// [design/aqh_top.sv]
// Operation
// - broadcast reject drops packets to node 3f
// - receiver reset self-clears at link idle
// - bus reset sets transmitter reset bit
// - store all responses or only solicited
// - retry limit bounds transmitter retries
// - timeout is seconds plus eighth-milliseconds
// - fraction field resets to 0320h
// - idle flag while transfer register empty
// - full flag per queue nibble
// - almost full at exactly one free
// - five-free flag at five or more free
// - empty flag lowest nibble bit
// - unused status bits read zero
// - request next write queues quadlet
// - request last write ends packet
// - response next write queues quadlet
// - response last write ends packet
// - request write clears written flag
// - response write clears written flag
// - written flags set on move, write-one clears
// - write while busy sets write error
// - response timeout raises timeout flag
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module aqh_top #(
    parameter int CYC_PER_UNIT = aqh_pkg::CYC_PER_UNIT
) (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // wishbone slave
    input  wire aqh_pkg::aqh_wb_req_t          wb_req,
    output aqh_pkg::aqh_wb_rsp_t               wb_rsp,
    // transmit queues toward the link, index 0 request, 1 response
    output aqh_pkg::aqh_tx_quad_t [1:0]        tx_quad,
    output logic                  [1:0]        tx_valid,
    input  wire logic             [1:0]        tx_ready,
    input  wire logic                          tx_retry,
    output logic                               tx_give_up,
    // receive path from the link, index 0 request, 1 response
    input  wire aqh_pkg::aqh_rx_quad_t         rx_in,
    output logic                               rx_in_ready,
    input  wire logic             [1:0]        rx_pop,
    // link state
    input  wire logic                          bus_reset,
    input  wire logic                          link_idle
);

    localparam int QD = aqh_pkg::QUEUE_DEPTH;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [3:0] fill_nibble(input logic [3:0] cnt);
        logic [3:0] free;
        free = 4'(QD) - cnt;
        fill_nibble = {free == 4'h0, free == 4'h1,
                       free >= 4'(aqh_pkg::FIVE_FREE),
                       cnt == 4'h0};
    endfunction

    function automatic logic [15:0] timeout_units(input logic [31:0] c);
        timeout_units = 16'(c[aqh_pkg::TOS_LSB +: 3] *
                            16'(aqh_pkg::UNITS_PER_SEC)) +
                        16'(c[12:0]);
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] control_reg;
    logic [31:0] control_next;
    logic [31:0] events_reg;
    logic [31:0] events_next;
    logic [31:0] status_word;
    logic [31:0] wmask;

    wire access    = wb_req.cyc & wb_req.stb & ~ack_reg;
    wire wr        = access & wb_req.we;
    wire rd        = access & ~wb_req.we;
    wire full_word = wb_req.sel == 4'hf;
    wire wr_ctrl   = wr & (wb_req.adr == aqh_pkg::ADDR_CONTROL);
    wire wr_events = wr & (wb_req.adr == aqh_pkg::ADDR_EVENTS);
    wire [1:0] wr_next = {wb_req.adr == aqh_pkg::ADDR_RSP_NEXT,
                          wb_req.adr == aqh_pkg::ADDR_REQ_NEXT};
    wire [1:0] wr_last = {wb_req.adr == aqh_pkg::ADDR_RSP_LAST,
                          wb_req.adr == aqh_pkg::ADDR_REQ_LAST};
    wire [1:0] load    = {2{wr & full_word}} & (wr_next | wr_last);

    assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
                    {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

    wire bcast_rej  = control_reg[aqh_pkg::BIT_BCAST];
    wire rx_reset   = control_reg[aqh_pkg::BIT_RX_RESET];
    wire tx_reset   = control_reg[aqh_pkg::BIT_TX_RESET];
    wire all_rsp    = control_reg[aqh_pkg::BIT_ALL_RSP];
    wire [3:0] retry_limit = control_reg[aqh_pkg::RETRY_LSB +: 4];

    // ------------------------------------------------------------
    // transmit queues
    // ------------------------------------------------------------
    logic [1:0] hold_busy;
    logic [1:0] move;
    logic [1:0] load_err;
    logic [1:0] pop;
    logic [1:0] pop_last;
    logic [3:0] tx_cnt [2];
    logic [3:0] pkt_cnt [2];

    for (genvar q = 0; q < 2; q++) begin : g_txq
        aqh_pkg::aqh_tx_quad_t hold_reg;
        aqh_pkg::aqh_tx_quad_t mem_reg [QD];
        logic                  busy_reg;
        logic [2:0]            wptr_reg;
        logic [2:0]            rptr_reg;
        logic [3:0]            cnt_reg;
        logic [3:0]            pkts_reg;

        // a second write before the quadlet moved is refused, not queued
        assign load_err[q]  = load[q] & busy_reg;
        assign move[q]      = busy_reg & (cnt_reg != 4'(QD));
        assign hold_busy[q] = busy_reg;
        assign tx_quad[q]   = mem_reg[rptr_reg];
        // held back until a whole packet is in, and while tx is in reset
        assign tx_valid[q]  = (pkts_reg != 4'h0) & ~tx_reset;
        assign pop[q]       = tx_valid[q] & tx_ready[q];
        assign pop_last[q]  = pop[q] & tx_quad[q].last;
        assign tx_cnt[q]    = cnt_reg;
        assign pkt_cnt[q]   = pkts_reg;

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                busy_reg <= 1'b0;
                hold_reg <= '0;
            end else if (load[q] && !busy_reg) begin
                busy_reg <= 1'b1;
                hold_reg <= {wb_req.dat, wr_last[q]};
            end else if (move[q]) begin
                busy_reg <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (move[q]) begin
                mem_reg[wptr_reg] <= hold_reg;
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                wptr_reg <= 3'h0;
                rptr_reg <= 3'h0;
                cnt_reg  <= 4'h0;
                pkts_reg <= 4'h0;
            end else begin
                wptr_reg <= wptr_reg + 3'(move[q]);
                rptr_reg <= rptr_reg + 3'(pop[q]);
                cnt_reg  <= cnt_reg + 4'(move[q]) - 4'(pop[q]);
                pkts_reg <= pkts_reg + 4'(move[q] & hold_reg.last)
                            - 4'(pop_last[q]);
            end
        end
    end

    // ------------------------------------------------------------
    // retry count, shared by the transmitter
    // ------------------------------------------------------------
    logic [3:0] retry_reg;

    // the link is told to give up; it drains the packet itself
    assign tx_give_up = retry_reg >= retry_limit;

    always_ff @(posedge core_clk) begin
        if (!rst_n || pop_last != 2'b00) begin
            retry_reg <= 4'h0;
        end else if (tx_retry && !tx_give_up) begin
            retry_reg <= retry_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // receive filter and queue occupancy
    // ------------------------------------------------------------
    logic [3:0] rx_cnt_reg [2];
    logic [1:0] rx_full;
    logic [1:0] rx_dec;

    wire rx_q      = rx_in.is_response;
    wire rej_bcast = bcast_rej & (rx_in.dest_node == aqh_pkg::BCAST_NODE);
    wire rej_rsp   = rx_in.is_response & ~rx_in.solicited & ~all_rsp;
    wire rx_reject = rej_bcast | rej_rsp;
    wire rx_accept = rx_in.valid & ~rx_reject & ~rx_full[rx_q] & ~rx_reset;
    wire rsp_match = rx_accept & rx_in.is_response & rx_in.solicited;

    // rejected quadlets are swallowed so the link never stalls on them
    assign rx_in_ready = rx_reject | (~rx_full[rx_q] & ~rx_reset);

    for (genvar q = 0; q < 2; q++) begin : g_rxq
        assign rx_full[q] = rx_cnt_reg[q] == 4'(QD);
        assign rx_dec[q]  = rx_pop[q] & (rx_cnt_reg[q] != 4'h0);

        always_ff @(posedge core_clk) begin
            if (!rst_n || rx_reset) begin
                rx_cnt_reg[q] <= 4'h0;
            end else begin
                rx_cnt_reg[q] <= rx_cnt_reg[q]
                                 + 4'(rx_accept & (rx_q == 1'(q)))
                                 - 4'(rx_dec[q]);
            end
        end
    end

    // ------------------------------------------------------------
    // split transaction timer
    // ------------------------------------------------------------
    logic        timer_on_reg;
    logic [15:0] unit_cnt_reg;
    logic [15:0] cyc_cnt_reg;

    wire unit_tick  = cyc_cnt_reg == 16'(CYC_PER_UNIT - 1);
    wire timed_out  = timer_on_reg & unit_tick &
                      (unit_cnt_reg == timeout_units(control_reg));

    always_ff @(posedge core_clk) begin
        if (!rst_n || rsp_match || timed_out) begin
            timer_on_reg <= 1'b0;
        end else if (pop_last[0]) begin
            timer_on_reg <= 1'b1;
        end
    end

    // a new request restarts the interval; only one is tracked at a time
    always_ff @(posedge core_clk) begin
        if (!rst_n || pop_last[0] || !timer_on_reg) begin
            cyc_cnt_reg  <= 16'h0;
            unit_cnt_reg <= 16'h0;
        end else begin
            cyc_cnt_reg  <= unit_tick ? 16'h0 : cyc_cnt_reg + 16'h1;
            unit_cnt_reg <= unit_cnt_reg + 16'(unit_tick);
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb begin
        control_next = control_reg;
        if (wr_ctrl) begin
            control_next = ((control_reg & ~wmask) | (wb_req.dat & wmask))
                           & aqh_pkg::CONTROL_MASK;
        end
        if (rx_reset && link_idle) begin
            control_next[aqh_pkg::BIT_RX_RESET] = 1'b0;
        end
        // bus reset wins over a software clear in the same cycle
        if (bus_reset) begin
            control_next[aqh_pkg::BIT_TX_RESET] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            control_reg <= aqh_pkg::CONTROL_RESET;
        end else begin
            control_reg <= control_next;
        end
    end

    // ------------------------------------------------------------
    // event flags, write one to clear, a set wins
    // ------------------------------------------------------------
    wire [31:0] w1c = wr_events ? (wb_req.dat & wmask) : 32'h0;

    always_comb begin
        events_next = events_reg & ~w1c;
        events_next[aqh_pkg::EV_REQ_WR] = (events_reg[aqh_pkg::EV_REQ_WR]
            & ~w1c[aqh_pkg::EV_REQ_WR] & ~load[0]) | move[0];
        events_next[aqh_pkg::EV_RSP_WR] = (events_reg[aqh_pkg::EV_RSP_WR]
            & ~w1c[aqh_pkg::EV_RSP_WR] & ~load[1]) | move[1];
        events_next[aqh_pkg::EV_REQ_ERR] |= load_err[0];
        events_next[aqh_pkg::EV_RSP_ERR] |= load_err[1];
        events_next[aqh_pkg::EV_TIMEOUT] |= timed_out;
        events_next = events_next & aqh_pkg::EVENTS_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            events_reg <= 32'h0;
        end else begin
            events_reg <= events_next;
        end
    end

    // ------------------------------------------------------------
    // status and read path
    // ------------------------------------------------------------
    assign status_word = {14'h0, ~hold_busy[1], ~hold_busy[0],
                          fill_nibble(rx_cnt_reg[1]),
                          fill_nibble(rx_cnt_reg[0]),
                          fill_nibble(tx_cnt[1]),
                          fill_nibble(tx_cnt[0])};

    // transfer registers and unmapped addresses read as zero
    wire [31:0] rd_mux =
        (wb_req.adr == aqh_pkg::ADDR_CONTROL) ? control_reg :
        (wb_req.adr == aqh_pkg::ADDR_STATUS)  ? status_word :
        (wb_req.adr == aqh_pkg::ADDR_EVENTS)  ? events_reg  : 32'h0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg   <= access;
            rdata_reg <= rd ? rd_mux : rdata_reg;
        end
    end

    assign wb_rsp = '{ack: ack_reg, dat: rdata_reg};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_moved_req;
        move[0] ##1 events_reg[aqh_pkg::EV_REQ_WR];
    endsequence

    property p_bcast;
        rx_in.valid && bcast_rej && rx_in.dest_node == aqh_pkg::BCAST_NODE
            && !rx_dec[0] && !rx_dec[1] && !rx_reset
        |=> $stable(rx_cnt_reg[0]) && $stable(rx_cnt_reg[1]);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast kept");

    property p_rx_reset;
        rx_reset && link_idle && !wr_ctrl |=> !rx_reset;
    endproperty
    a_rx_reset: assert property (p_rx_reset) else $error("rx reset stuck");

    property p_bus_reset;
        bus_reset |=> tx_reset ##0 tx_valid == 2'b00;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("tx not held");

    property p_unsolicited;
        rx_in.valid && rx_in.is_response && !rx_in.solicited && !all_rsp
            && !rx_dec[1] && !rx_reset |=> $stable(rx_cnt_reg[1]);
    endproperty
    a_unsolicited: assert property (p_unsolicited) else $error("kept rsp");

    property p_req_written;
        (load[0] || hold_busy[0]) && !move[0]
            |=> !events_reg[aqh_pkg::EV_REQ_WR];
    endproperty
    a_req_written: assert property (p_req_written) else $error("flag");

    property p_moved;
        move[0] |-> s_moved_req;
    endproperty
    a_moved: assert property (p_moved) else $error("written not set");

    property p_write_error;
        load[0] && hold_busy[0] |=> events_reg[aqh_pkg::EV_REQ_ERR];
    endproperty
    a_write_error: assert property (p_write_error) else $error("no err");

    property p_eligible;
        tx_valid[0] |-> pkt_cnt[0] != 4'h0 && tx_cnt[0] >= pkt_cnt[0];
    endproperty
    a_eligible: assert property (p_eligible) else $error("early send");

    property p_status;
        $rose(status_word[3]) |-> !status_word[1] && !status_word[0]
            && $past(status_word[2]);
    endproperty
    a_status: assert property (p_status) else $error("bad fill flags");

    property p_timeout;
        timed_out |=> events_reg[aqh_pkg::EV_TIMEOUT] && !timer_on_reg;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no timeout");

    property p_ack;
        access |=> ack_reg ##1 !ack_reg;
    endproperty
    a_ack: assert property (p_ack) else $error("bad ack");

endmodule

`default_nettype wire

// [sim/aqh_link_model.sv]
`timescale 1ns/1ps
`default_nettype none

module aqh_link_model (
    // clock
    input  wire logic                        core_clk,
    // transmit side
    input  wire aqh_pkg::aqh_tx_quad_t [1:0] tx_quad,
    input  wire logic                  [1:0] tx_valid,
    output logic                       [1:0] tx_ready,
    output logic                             tx_retry,
    // receive side
    output aqh_pkg::aqh_rx_quad_t            rx_in,
    input  wire logic                        rx_in_ready,
    output logic                       [1:0] rx_pop
);
    // ------------------------------------------------------------
    // transmit drain
    // ------------------------------------------------------------
    logic        stall = 1'b0;
    int          send_fail = 0;
    int          pop_cnt [2] = '{0, 0};
    logic [31:0] last_data [2];

    // ready follows stall only, so no loop through tx_valid
    assign tx_ready = {2{~stall}};

    initial begin
        tx_retry = 1'b0;
        rx_pop   = 2'b00;
        rx_in    = '0;
    end

    always @(posedge core_clk) begin
        for (int q = 0; q < 2; q++) begin
            if (tx_valid[q] && tx_ready[q]) begin
                pop_cnt[q]++;
                last_data[q] = tx_quad[q].data;
            end
        end
    end

    // ------------------------------------------------------------
    // receive feed and retry reports
    // ------------------------------------------------------------
    task automatic send(input logic [5:0] dest, input logic rsp,
                        input logic sol);
        int n;
        n = 0;
        @(posedge core_clk);
        rx_in <= '{1'b1, dest, rsp, sol};
        do begin
            @(posedge core_clk);
            n++;
        end while (rx_in_ready !== 1'b1 && n < 20);
        if (rx_in_ready !== 1'b1) begin
            send_fail++;
        end
        // released fields show the inverse so stale values cannot match
        rx_in <= '{1'b0, ~dest, ~rsp, ~sol};
    endtask

    task automatic take(input logic [1:0] m);
        @(posedge core_clk);
        rx_pop <= m;
        @(posedge core_clk);
        rx_pop <= 2'b00;
    endtask

    task automatic retry();
        @(posedge core_clk);
        tx_retry <= 1'b1;
        @(posedge core_clk);
        tx_retry <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [sim/test_async_queue_host_interface.sv]
`timescale 1ns/1ps
`default_nettype none

module test_async_queue_host_interface;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                        core_clk  = 1'b0;
    logic                        rst_n     = 1'b0;
    logic                        bus_reset = 1'b0;
    logic                        link_idle = 1'b0;
    aqh_pkg::aqh_wb_req_t        wb_req    = '0;
    aqh_pkg::aqh_wb_rsp_t        wb_rsp;
    aqh_pkg::aqh_tx_quad_t [1:0] tx_quad;
    aqh_pkg::aqh_rx_quad_t       rx_in;
    logic                  [1:0] tx_valid;
    logic                  [1:0] tx_ready;
    logic                  [1:0] rx_pop;
    logic                        tx_retry;
    logic                        tx_give_up;
    logic                        rx_in_ready;
    logic                 [31:0] rdat;
    int                          error_cnt    = 0;
    int                          total_checks = 0;

    always #10 core_clk = ~core_clk;

    // short timeout unit keeps the split timeout at 12 cycles
    aqh_top #(.CYC_PER_UNIT(4)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .tx_quad(tx_quad), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_retry(tx_retry), .tx_give_up(tx_give_up),
        .rx_in(rx_in), .rx_in_ready(rx_in_ready), .rx_pop(rx_pop),
        .bus_reset(bus_reset), .link_idle(link_idle));

    aqh_link_model link (
        .core_clk(core_clk), .tx_quad(tx_quad), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_retry(tx_retry), .rx_in(rx_in),
        .rx_in_ready(rx_in_ready), .rx_pop(rx_pop));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rdat = wb_rsp.dat;
        wb_req <= '0;
        if (wb_rsp.ack !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk32(nm, e, rdat);
    endtask

    task automatic ct(input logic [31:0] e);
        rd("control", aqh_pkg::ADDR_CONTROL, e);
    endtask

    task automatic st(input logic [31:0] e);
        rd("status", aqh_pkg::ADDR_STATUS, e);
    endtask

    task automatic ev(input logic [31:0] e);
        rd("events", aqh_pkg::ADDR_EVENTS, e);
    endtask

    function automatic logic [3:0] nib(input int used);
        int fr;
        fr = aqh_pkg::QUEUE_DEPTH - used;
        return {fr == 0, fr == 1, fr >= aqh_pkg::FIVE_FREE, used == 0};
    endfunction

    function automatic logic [31:0] stat(input int rr, rq, tr, tq);
        return {14'h0, 2'b11, nib(rr), nib(rq), nib(tr), nib(tq)};
    endfunction

    task automatic waitp(input int q, input int n);
        int k;
        k = 0;
        while (link.pop_cnt[q] != n && k < 200) begin
            @(posedge core_clk);
            k++;
        end
        chk32("pop count", 32'(n), 32'(link.pop_cnt[q]));
        if (link.pop_cnt[q] != n) begin
            final_report();
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk) chk1("give up", 1'b1, tx_give_up);
        ct(32'h00300320);
        st(32'h00033333);
        rd("unmapped", 8'hfc, 32'h0);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, aqh_pkg::ADDR_REQ_NEXT, 32'hc0de0000 + i);
            st(stat(0, 0, 0, i + 1));
        end
        wb(1'b1, aqh_pkg::ADDR_REQ_LAST, 32'hc0de0007);
        st(stat(0, 0, 0, 8));
        ev(32'h1);
        // queue full: first extra write waits, second one is refused
        wb(1'b1, aqh_pkg::ADDR_REQ_NEXT, 32'hc0de0008);
        wb(1'b1, aqh_pkg::ADDR_REQ_NEXT, 32'hc0de0009);
        ev(32'h4);
        st(stat(0, 0, 0, 8) & ~32'h00010000);
        @(negedge core_clk) chk1("tx valid", 1'b0, tx_valid[0]);
        wb(1'b1, aqh_pkg::ADDR_CONTROL, 32'h2);
        waitp(0, 8);
        chk32("last data", 32'hc0de0007, link.last_data[0]);
        wb(1'b1, aqh_pkg::ADDR_REQ_LAST, 32'hc0de000a);
        waitp(0, 10);
        chk32("last data", 32'hc0de000a, link.last_data[0]);
        repeat (20) @(posedge core_clk);
        ev(32'h85);
        wb(1'b1, aqh_pkg::ADDR_EVENTS, 32'h85);
        ev(32'h0);
        @(posedge core_clk) link.stall <= 1'b1;
        wb(1'b1, aqh_pkg::ADDR_RSP_NEXT, 32'h5a5a0001);
        @(negedge core_clk) chk1("tx valid", 1'b0, tx_valid[1]);
        wb(1'b1, aqh_pkg::ADDR_RSP_LAST, 32'h5a5a0002);
        st(stat(0, 0, 2, 0));
        ev(32'h2);
        @(posedge core_clk) link.stall <= 1'b0;
        waitp(1, 2);
        chk32("last data", 32'h5a5a0002, link.last_data[1]);
        @(posedge core_clk) bus_reset <= 1'b1;
        @(posedge core_clk) bus_reset <= 1'b0;
        ct(32'h00200002);
        wb(1'b1, aqh_pkg::ADDR_CONTROL, 32'h00400002);
        @(negedge core_clk) chk1("rx ready", 1'b0, rx_in_ready);
        ct(32'h00400002);
        @(posedge core_clk) link_idle <= 1'b1;
        ct(32'h2);
        @(posedge core_clk) link_idle <= 1'b0;
        wb(1'b1, aqh_pkg::ADDR_CONTROL, 32'h00800002);
        link.send(6'h3f, 1'b0, 1'b0);
        link.send(6'h01, 1'b0, 1'b0);
        link.send(6'h01, 1'b1, 1'b0);
        link.send(6'h01, 1'b1, 1'b1);
        wb(1'b1, aqh_pkg::ADDR_CONTROL, 32'h00100002);
        link.send(6'h3f, 1'b0, 1'b0);
        link.send(6'h01, 1'b1, 1'b0);
        st(stat(2, 2, 0, 0));
        chk32("send timeout", 32'h0, 32'(link.send_fail));
        link.take(2'b10);
        st(stat(1, 2, 0, 0));
        wb(1'b1, aqh_pkg::ADDR_CONTROL, 32'h00020002);
        link.retry();
        @(negedge core_clk) chk1("give up", 1'b0, tx_give_up);
        link.retry();
        @(negedge core_clk) chk1("give up", 1'b1, tx_give_up);
        final_report();
    end
endmodule

`default_nettype wire
